/* File: src/tmsw_defs.svh */
/*
 * Offsets, field positions and reset values of the switch configuration bank.
 * Assumes an 8-bit register address space behind the serial control logic.
 */
`ifndef TMSW_DEFS_SVH
`define TMSW_DEFS_SVH

// Register offsets
`define TMSW_OFS_RECEIVER_SETTINGS     8'h10
`define TMSW_OFS_INPUT_TERMINATION     8'h11
`define TMSW_OFS_RECEIVE_EQUALIZER     8'h14
`define TMSW_OFS_TRANSMITTER_SETTINGS  8'h20
`define TMSW_OFS_SOURCE_POLARITY       8'h80
`define TMSW_OFS_FIRST_LANE_MAP        8'h81
`define TMSW_OFS_SECOND_LANE_MAP       8'h82

// Reset values
`define TMSW_RST_RECEIVER_SETTINGS     8'h01
`define TMSW_RST_INPUT_TERMINATION     8'h00
`define TMSW_RST_RECEIVE_EQUALIZER     8'hFF
`define TMSW_RST_TRANSMITTER_SETTINGS  8'h03
`define TMSW_RST_SOURCE_POLARITY       8'h00
`define TMSW_RST_FIRST_LANE_MAP        8'hE4
`define TMSW_RST_SECOND_LANE_MAP       8'hE4

// Writable bits; the rest read as zero
`define TMSW_MASK_RECEIVER_SETTINGS    8'h01
`define TMSW_MASK_TRANSMITTER_SETTINGS 8'h0F

// Field positions
`define TMSW_BIT_TERM_MODE             0
`define TMSW_BIT_OUT_CURRENT           0
`define TMSW_BIT_OUT_TERM              1
`define TMSW_POS_PREEMPH               2
`define TMSW_POS_FIRST_POL             0
`define TMSW_POS_SECOND_POL            4

// Answer to an unmapped read
`define TMSW_UNMAPPED_READ             8'h00

`endif

/* File: src/tmsw_pkg.sv */
/*
 * Types used by the switch configuration bank; its lane router uses none of them.
 * Assumes tmsw_defs.svh carries all numeric constants.
 */
package tmsw_pkg;

    typedef logic [7:0] tmsw_byte_t;
    typedef logic [3:0] tmsw_lanes_t;
    typedef logic [1:0] tmsw_lane_idx_t;

    // Pre-emphasis levels: 0 dB, 2 dB, 4 dB, 6 dB
    typedef enum logic [1:0] {
        tmsw_pe_none,
        tmsw_pe_low,
        tmsw_pe_medium,
        tmsw_pe_high
    } tmsw_preemph_e;

endpackage

/* File: src/tmsw_lane_router.sv */
/*
 * Combinational lane router: polarity per input lane, then per-output
 * selection of one input lane of the chosen source.
 * Assumes the caller registers the outputs.
 */
`timescale 1ns/10ps
`default_nettype none

module tmsw_lane_router (
    input  wire logic [3:0] src_sel,       // 0 first source, 1 second
    input  wire logic [7:0] first_map,     // Two bits per output lane
    input  wire logic [7:0] second_map,    // Two bits per output lane
    input  wire logic [3:0] first_pol,     // Swap legs per input lane
    input  wire logic [3:0] second_pol,    // Swap legs per input lane
    input  wire logic [3:0] first_true,    // First source true legs
    input  wire logic [3:0] first_comp,    // First source complement legs
    input  wire logic [3:0] second_true,   // Second source true legs
    input  wire logic [3:0] second_comp,   // Second source complement legs
    output logic      [3:0] pos_leg,       // Output positive legs
    output logic      [3:0] neg_leg,       // Output negative legs
    output logic      [7:0] lane_select    // Active map, two bits a lane
);

    logic [3:0] a_pos;
    logic [3:0] a_neg;
    logic [3:0] b_pos;
    logic [3:0] b_neg;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            a_pos[i] = first_pol[i]  ? first_comp[i]  : first_true[i];
            a_neg[i] = first_pol[i]  ? first_true[i]  : first_comp[i];
            b_pos[i] = second_pol[i] ? second_comp[i] : second_true[i];
            b_neg[i] = second_pol[i] ? second_true[i] : second_comp[i];
        end
    end

    always_comb begin
        lane_select = src_sel[0] ? second_map : first_map;
        for (int o = 0; o < 4; o++) begin
            if (src_sel[0]) begin
                pos_leg[o] = b_pos[second_map[2*o +: 2]];
                neg_leg[o] = b_neg[second_map[2*o +: 2]];
            end else begin
                pos_leg[o] = a_pos[first_map[2*o +: 2]];
                neg_leg[o] = a_neg[first_map[2*o +: 2]];
            end
        end
    end

endmodule

`default_nettype wire

/* File: src/tmsw_config_regs.sv */
/*
 * Configuration bank of a 2:1 differential video switch: input termination
 * and equalizer per lane, output drive settings, polarity and lane maps.
 * Assumes the serial control logic supplies clk, rstn and a simple
 * byte-wide register port; the source select comes from the mode register
 * held in that logic.
 */
`timescale 1ns/10ps
`default_nettype none

`include "tmsw_defs.svh"

module tmsw_config_regs (
    input  wire logic       clk,               // 100 MHz clock
    input  wire logic       rstn,              // Sync reset, active low
    input  wire logic       reg_wr_en,         // Write strobe
    input  wire logic       reg_rd_en,         // Read strobe
    input  wire logic [7:0] reg_addr,          // Register offset
    input  wire logic [7:0] reg_wr_data,       // Write data
    output logic      [7:0] reg_rd_data,       // Read data, next cycle
    output logic            reg_rd_valid,      // Read data valid pulse
    input  wire logic       highspeed_source_select, // 0 first, 1 second
    input  wire logic [3:0] first_input_true_leg,    // First true legs
    input  wire logic [3:0] first_input_comp_leg,    // First complements
    input  wire logic [3:0] second_input_true_leg,   // Second true legs
    input  wire logic [3:0] second_input_comp_leg,   // Second complements
    output logic      [3:0] output_positive_leg,     // Output positive legs
    output logic      [3:0] output_negative_leg,     // Output negative legs
    output logic      [7:0] output_lane_select,      // Active map
    output logic      [3:0] first_term_connect,      // Per lane 0-3
    output logic      [3:0] second_term_connect,     // Per lane 0-3
    output logic      [3:0] first_eq_high,           // Per lane 0-3
    output logic      [3:0] second_eq_high,          // Per lane 0-3
    output logic      [1:0] output_preemphasis_level, // All outputs
    output logic            output_termination_on,    // All outputs
    output logic            output_current_level      // 1 means 20 mA
);

    // Register storage
    logic [7:0] receiver_settings_q;
    logic [7:0] receiver_settings_d;
    logic [7:0] input_termination_control_q;
    logic [7:0] input_termination_control_d;
    logic [7:0] receive_equalizer_q;
    logic [7:0] receive_equalizer_d;
    logic [7:0] transmitter_settings_q;
    logic [7:0] transmitter_settings_d;
    logic [7:0] source_polarity_control_q;
    logic [7:0] source_polarity_control_d;
    logic [7:0] first_source_lane_map_q;
    logic [7:0] first_source_lane_map_d;
    logic [7:0] second_source_lane_map_q;
    logic [7:0] second_source_lane_map_d;

    // Read port
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       rd_valid_q;
    logic       rd_valid_d;

    // Decoded controls
    logic [3:0] first_term_q;
    logic [3:0] first_term_d;
    logic [3:0] second_term_q;
    logic [3:0] second_term_d;
    logic [3:0] first_eq_q;
    logic [3:0] first_eq_d;
    logic [3:0] second_eq_q;
    logic [3:0] second_eq_d;
    logic [1:0] preemph_q;
    logic [1:0] preemph_d;
    logic       out_term_q;
    logic       out_term_d;
    logic       out_current_q;
    logic       out_current_d;

    // Routed lanes
    logic [3:0] pos_leg_q;
    logic [3:0] pos_leg_d;
    logic [3:0] neg_leg_q;
    logic [3:0] neg_leg_d;
    logic [7:0] lane_sel_q;
    logic [7:0] lane_sel_d;

    // Named level, for readability in waveforms
    tmsw_pkg::tmsw_preemph_e preemph_level;

    // Upper nibble is reversed: bit 7 is lane 0, bit 4 is lane 3
    function automatic tmsw_pkg::tmsw_lanes_t upper_lanes(
        input tmsw_pkg::tmsw_byte_t field
    );
        upper_lanes = {field[4], field[5], field[6], field[7]};
    endfunction

    // Exact match only; no offset aliases another
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // Register writes; reserved bits are never stored
    // A read in the same cycle still sees the old value
    always_comb begin
        receiver_settings_d         = receiver_settings_q;
        input_termination_control_d = input_termination_control_q;
        receive_equalizer_d         = receive_equalizer_q;
        transmitter_settings_d      = transmitter_settings_q;
        source_polarity_control_d   = source_polarity_control_q;
        first_source_lane_map_d     = first_source_lane_map_q;
        second_source_lane_map_d    = second_source_lane_map_q;
        // Offsets are distinct, so at most one branch fires
        if (reg_wr_en) begin
            if (addr_hit(reg_addr, `TMSW_OFS_RECEIVER_SETTINGS)) begin
                receiver_settings_d =
                    reg_wr_data & `TMSW_MASK_RECEIVER_SETTINGS;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_INPUT_TERMINATION)) begin
                input_termination_control_d = reg_wr_data;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_RECEIVE_EQUALIZER)) begin
                receive_equalizer_d = reg_wr_data;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_TRANSMITTER_SETTINGS)) begin
                transmitter_settings_d =
                    reg_wr_data & `TMSW_MASK_TRANSMITTER_SETTINGS;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_SOURCE_POLARITY)) begin
                source_polarity_control_d = reg_wr_data;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_FIRST_LANE_MAP)) begin
                first_source_lane_map_d = reg_wr_data;
            end
            if (addr_hit(reg_addr, `TMSW_OFS_SECOND_LANE_MAP)) begin
                second_source_lane_map_d = reg_wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            receiver_settings_q         <= `TMSW_RST_RECEIVER_SETTINGS;
            input_termination_control_q <= `TMSW_RST_INPUT_TERMINATION;
            receive_equalizer_q         <= `TMSW_RST_RECEIVE_EQUALIZER;
            transmitter_settings_q      <= `TMSW_RST_TRANSMITTER_SETTINGS;
            source_polarity_control_q   <= `TMSW_RST_SOURCE_POLARITY;
            first_source_lane_map_q     <= `TMSW_RST_FIRST_LANE_MAP;
            second_source_lane_map_q    <= `TMSW_RST_SECOND_LANE_MAP;
        end else begin
            receiver_settings_q         <= receiver_settings_d;
            input_termination_control_q <= input_termination_control_d;
            receive_equalizer_q         <= receive_equalizer_d;
            transmitter_settings_q      <= transmitter_settings_d;
            source_polarity_control_q   <= source_polarity_control_d;
            first_source_lane_map_q     <= first_source_lane_map_d;
            second_source_lane_map_q    <= second_source_lane_map_d;
        end
    end

    // Read path; unmapped offsets answer zero
    // Data holds between reads, so a slow host may sample late
    always_comb begin
        rd_valid_d = reg_rd_en;
        rd_data_d  = rd_data_q;
        if (reg_rd_en) begin
            case (reg_addr)
                `TMSW_OFS_RECEIVER_SETTINGS:
                    rd_data_d = receiver_settings_q;
                `TMSW_OFS_INPUT_TERMINATION:
                    rd_data_d = input_termination_control_q;
                `TMSW_OFS_RECEIVE_EQUALIZER:
                    rd_data_d = receive_equalizer_q;
                `TMSW_OFS_TRANSMITTER_SETTINGS:
                    rd_data_d = transmitter_settings_q;
                `TMSW_OFS_SOURCE_POLARITY:
                    rd_data_d = source_polarity_control_q;
                `TMSW_OFS_FIRST_LANE_MAP:
                    rd_data_d = first_source_lane_map_q;
                `TMSW_OFS_SECOND_LANE_MAP:
                    rd_data_d = second_source_lane_map_q;
                default:
                    rd_data_d = `TMSW_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Decoded analog controls, one cycle behind the stored value
    always_comb begin
        if (receiver_settings_q[`TMSW_BIT_TERM_MODE]) begin
            first_term_d  = 4'hF;
            second_term_d = 4'hF;
        end else begin
            // A 0 bit leaves that lane open
            first_term_d  =
                input_termination_control_q[3:0];
            second_term_d =
                upper_lanes(input_termination_control_q);
        end
        first_eq_d    = receive_equalizer_q[3:0];
        second_eq_d   = upper_lanes(receive_equalizer_q);
        // Two bits cover all four levels; no illegal code exists
        preemph_level = tmsw_pkg::tmsw_preemph_e'(
            transmitter_settings_q[`TMSW_POS_PREEMPH +: 2]);
        preemph_d     = preemph_level;
        out_term_d    =
            transmitter_settings_q[`TMSW_BIT_OUT_TERM];
        out_current_d =
            transmitter_settings_q[`TMSW_BIT_OUT_CURRENT];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Same as decoding the register reset values
            first_term_q  <= 4'hF;
            second_term_q <= 4'hF;
            first_eq_q    <= 4'hF;
            second_eq_q   <= 4'hF;
            preemph_q     <= 2'h0;
            out_term_q    <= 1'b1;
            out_current_q <= 1'b1;
        end else begin
            first_term_q  <= first_term_d;
            second_term_q <= second_term_d;
            first_eq_q    <= first_eq_d;
            second_eq_q   <= second_eq_d;
            preemph_q     <= preemph_d;
            out_term_q    <= out_term_d;
            out_current_q <= out_current_d;
        end
    end

    // Lane routing; registered so every output leaves a flip-flop
    // Costs one cycle of lane latency; the router itself is glue only
    tmsw_lane_router tmsw_lane_router_i (
        .src_sel     ({3'h0, highspeed_source_select}),
        .first_map   (first_source_lane_map_q),
        .second_map  (second_source_lane_map_q),
        .first_pol   (source_polarity_control_q[`TMSW_POS_FIRST_POL +: 4]),
        .second_pol  (source_polarity_control_q[`TMSW_POS_SECOND_POL +: 4]),
        .first_true  (first_input_true_leg),
        .first_comp  (first_input_comp_leg),
        .second_true (second_input_true_leg),
        .second_comp (second_input_comp_leg),
        .pos_leg     (pos_leg_d),
        .neg_leg     (neg_leg_d),
        .lane_select (lane_sel_d)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Quiet legs until the first routed edge
            pos_leg_q  <= 4'h0;
            neg_leg_q  <= 4'h0;
            lane_sel_q <= `TMSW_RST_FIRST_LANE_MAP;
        end else begin
            pos_leg_q  <= pos_leg_d;
            neg_leg_q  <= neg_leg_d;
            lane_sel_q <= lane_sel_d;
        end
    end

    // No logic after the registers, so outputs are glitch free
    assign reg_rd_data              = rd_data_q;
    assign reg_rd_valid             = rd_valid_q;
    assign output_positive_leg      = pos_leg_q;
    assign output_negative_leg      = neg_leg_q;
    assign output_lane_select       = lane_sel_q;
    assign first_term_connect       = first_term_q;
    assign second_term_connect      = second_term_q;
    assign first_eq_high            = first_eq_q;
    assign second_eq_high           = second_eq_q;
    assign output_preemphasis_level = preemph_q;
    assign output_termination_on    = out_term_q;
    assign output_current_level     = out_current_q;

endmodule

`default_nettype wire

/* File: bench/tmsw_regs_checker.sv */
/* Concurrent checks on the switch configuration bank's ports.
   Assumes one clock, a synchronous active-low reset, bound by name. */
`timescale 1ns/10ps
`default_nettype none

module tmsw_regs_checker (
    input wire logic       clk,                      // Clock
    input wire logic       rstn,                     // Sync reset
    input wire logic       reg_wr_en,                // Write strobe
    input wire logic       reg_rd_en,                // Read strobe
    input wire logic [7:0] reg_addr,                 // Offset
    input wire logic [7:0] reg_wr_data,              // Write data
    input wire logic [7:0] reg_rd_data,              // Read data
    input wire logic       reg_rd_valid,             // Read valid
    input wire logic       highspeed_source_select,  // Source
    input wire logic [3:0] first_input_true_leg,     // Legs in
    input wire logic [3:0] first_input_comp_leg,     // Legs in
    input wire logic [3:0] second_input_true_leg,    // Legs in
    input wire logic [3:0] second_input_comp_leg,    // Legs in
    input wire logic [3:0] output_positive_leg,      // Legs out
    input wire logic [3:0] output_negative_leg,      // Legs out
    input wire logic [7:0] output_lane_select,       // Active map
    input wire logic [3:0] first_term_connect,       // Termination
    input wire logic [3:0] second_term_connect,      // Termination
    input wire logic [3:0] first_eq_high,            // Equalizer
    input wire logic [3:0] second_eq_high,           // Equalizer
    input wire logic [1:0] output_preemphasis_level, // Pre-emphasis
    input wire logic       output_termination_on,    // Out termination
    input wire logic       output_current_level      // Drive current
);
    logic       mode_d, mode_q;
    logic [7:0] pt_d, pt_q, ma_d, ma_q, mb_d, mb_q;
    logic [3:0] x_d, x_q, x_exp;
    wire  logic [3:0] pt_rev = {pt_q[4], pt_q[5], pt_q[6], pt_q[7]};

    // Leg difference survives any polarity swap, so no shadow of it
    always_comb begin
        mode_d = mode_q;
        pt_d = pt_q;
        ma_d = ma_q;
        mb_d = mb_q;
        x_d = highspeed_source_select ?
              (second_input_true_leg ^ second_input_comp_leg) :
              (first_input_true_leg ^ first_input_comp_leg);
        if (reg_wr_en && reg_addr == 8'h10) mode_d = reg_wr_data[0];
        if (reg_wr_en && reg_addr == 8'h11) pt_d = reg_wr_data;
        if (reg_wr_en && reg_addr == 8'h81) ma_d = reg_wr_data;
        if (reg_wr_en && reg_addr == 8'h82) mb_d = reg_wr_data;
        if (!rstn) begin
            {mode_d, pt_d, ma_d, mb_d, x_d} =
                {1'b1, 8'h00, 8'hE4, 8'hE4, 4'h0};
        end
        for (int o = 0; o < 4; o++) begin
            x_exp[o] = x_q[output_lane_select[2*o +: 2]];
        end
    end

    always_ff @(posedge clk) begin
        {mode_q, pt_q, ma_q, mb_q, x_q} <= {mode_d, pt_d, ma_d, mb_d, x_d};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_wr20; reg_wr_en && reg_addr == 8'h20; endsequence
    sequence s_wr14; reg_wr_en && reg_addr == 8'h14; endsequence

    property p_rd_valid;
        1'b1 |=> reg_rd_valid == $past(reg_rd_en);
    endproperty
    property p_rd_hold; !reg_rd_en |=> $stable(reg_rd_data); endproperty
    property p_unmapped;
        reg_rd_en && !(reg_addr inside {8'h10, 8'h11, 8'h14, 8'h20, 8'h80,
            8'h81, 8'h82}) |=> reg_rd_data == 8'h00;
    endproperty
    property p_preemph;
        s_wr20 |-> ##2 output_preemphasis_level == $past(reg_wr_data[3:2], 2);
    endproperty
    property p_out_term;
        s_wr20 |-> ##2 output_termination_on == $past(reg_wr_data[1], 2);
    endproperty
    property p_current;
        s_wr20 |-> ##2 output_current_level == $past(reg_wr_data[0], 2);
    endproperty
    property p_eq;
        s_wr14 |-> ##2 first_eq_high == $past(reg_wr_data[3:0], 2) &&
            second_eq_high == $past({reg_wr_data[4], reg_wr_data[5],
            reg_wr_data[6], reg_wr_data[7]}, 2);
    endproperty
    property p_auto_term;
        mode_q |=> first_term_connect == 4'hF && second_term_connect == 4'hF;
    endproperty
    property p_man_term;
        !mode_q |=> first_term_connect == $past(pt_q[3:0]) &&
            second_term_connect == $past(pt_rev);
    endproperty
    property p_lane_sel;
        $past(rstn) |->
            output_lane_select == $past(highspeed_source_select ? mb_q : ma_q);
    endproperty
    property p_leg_diff;
        (output_positive_leg ^ output_negative_leg) == x_exp;
    endproperty

    a_rd_valid: assert property (p_rd_valid)
        else $error("read valid not one cycle after read");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_preemph: assert property (p_preemph)
        else $error("pre-emphasis wrong");
    a_out_term: assert property (p_out_term)
        else $error("output termination wrong");
    a_current: assert property (p_current)
        else $error("output current wrong");
    a_eq: assert property (p_eq)
        else $error("equalizer lanes wrong");
    a_auto_term: assert property (p_auto_term)
        else $error("auto termination not all connected");
    a_man_term: assert property (p_man_term)
        else $error("manual termination wrong");
    a_lane_sel: assert property (p_lane_sel)
        else $error("active map wrong");
    a_leg_diff: assert property (p_leg_diff)
        else $error("routed lane wrong");
endmodule

bind tmsw_config_regs tmsw_regs_checker tmsw_regs_checker_i (
    .clk, .rstn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
    .reg_rd_data, .reg_rd_valid, .highspeed_source_select,
    .first_input_true_leg, .first_input_comp_leg, .second_input_true_leg,
    .second_input_comp_leg, .output_positive_leg, .output_negative_leg,
    .output_lane_select, .first_term_connect, .second_term_connect,
    .first_eq_high, .second_eq_high, .output_preemphasis_level,
    .output_termination_on, .output_current_level);

`default_nettype wire

/* File: bench/test_tmsw_config_regs.sv */
/* Self-checking bench for the switch configuration bank.
   Assumes the byte register port and one-cycle lane latency. */
`timescale 1ns/10ps
`default_nettype none

module test_tmsw_config_regs;
    logic       clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic       hs_sel = 1'b0, rvalid, oterm, ocur;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lsel;
    logic [3:0] at = 4'h0, ac = 4'h0, bt = 4'h0, bc = 4'h0, pos, neg;
    logic [3:0] tfa, tfb, eqa, eqb;
    logic [1:0] pe;
    int         bad_count = 0, n_tests = 0, cyc = 0;
    logic [7:0] ofs [8] = '{8'h10, 8'h11, 8'h14, 8'h20, 8'h80, 8'h81, 8'h82,
                            8'h12};
    logic [7:0] rstv [8] = '{8'h01, 8'h00, 8'hFF, 8'h03, 8'h00, 8'hE4, 8'hE4,
                             8'h00};
    wire  logic [23:0] dec = {tfa, tfb, eqa, eqb, 4'h0, pe, oterm, ocur};

    tmsw_config_regs tmsw_config_regs_i (
        .clk(clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
        .reg_rd_valid(rvalid), .highspeed_source_select(hs_sel),
        .first_input_true_leg(at), .first_input_comp_leg(ac),
        .second_input_true_leg(bt), .second_input_comp_leg(bc),
        .output_positive_leg(pos), .output_negative_leg(neg),
        .output_lane_select(lsel), .first_term_connect(tfa),
        .second_term_connect(tfb), .first_eq_high(eqa), .second_eq_high(eqb),
        .output_preemphasis_level(pe), .output_termination_on(oterm),
        .output_current_level(ocur));

    always #5 clk = ~clk;

    function automatic logic [3:0] rev(input logic [7:0] b);
        return {b[4], b[5], b[6], b[7]};
    endfunction

    function automatic logic [23:0] expdec(input logic m, input logic [7:0] p,
            input logic [7:0] e, input logic [7:0] t);
        return {m ? 4'hF : p[3:0], m ? 4'hF : rev(p), e[3:0], rev(e), 4'h0,
                t[3:0]};
    endfunction

    // Legs as {negative, positive}; polarity follows the input lane
    function automatic logic [7:0] route(input logic [7:0] m,
            input logic [3:0] p, input logic [3:0] t, input logic [3:0] c);
        logic [7:0] r;
        for (int o = 0; o < 4; o++) begin
            r[o] = p[m[2*o +: 2]] ? c[m[2*o +: 2]] : t[m[2*o +: 2]];
            r[o+4] = p[m[2*o +: 2]] ? t[m[2*o +: 2]] : c[m[2*o +: 2]];
        end
        return r;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // Strobes stay up between back-to-back calls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rd_en = 1'b0;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wr_en = 1'b0;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        chk({23'h0, rvalid}, 24'h1);
        chk({16'h0, rdata}, {16'h0, e});
    endtask

    task automatic idle(input int n);
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        logic [7:0]  tx;
        logic [23:0] ex;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        chk(dec, expdec(1'b1, 8'h00, 8'hFF, 8'h03));
        chk({16'h0, lsel}, 24'hE4);
        for (int i = 0; i < 8; i++) rd(ofs[i], rstv[i]);
        $display("reset test done");
        wr(8'h10, 8'hFE);
        wr(8'h20, 8'hF0);
        wr(8'h11, 8'h2D);
        wr(8'h14, 8'h35);
        wr(8'h77, 8'hAA);
        rd(8'h10, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h11, 8'h2D);
        rd(8'h14, 8'h35);
        rd(8'h77, 8'h00);
        chk(dec, expdec(1'b0, 8'h2D, 8'h35, 8'h00));
        wr(8'h10, 8'h01);
        idle(1);
        chk(dec, expdec(1'b1, 8'h2D, 8'h35, 8'h00));
        wr(8'h10, 8'h00);
        idle(1);
        chk(dec, expdec(1'b0, 8'h2D, 8'h35, 8'h00));
        $display("termination test done");
        for (int i = 0; i < 4; i++) begin
            tx = {4'h0, i[1:0], i[1:0]};
            wr(8'h20, tx);
            idle(1);
            chk(dec, expdec(1'b0, 8'h2D, 8'h35, tx));
            rd(8'h20, tx);
        end
        $display("transmitter test done");
        wr(8'h81, 8'h1B);
        wr(8'h82, 8'h4E);
        wr(8'h80, 8'hA5);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 16; k++) begin
                hs_sel = s[0];
                at = k[3:0];
                ac = k[3:0] ^ 4'h6;
                bt = ~k[3:0];
                bc = k[3:0] ^ 4'h9;
                idle(1);
                ex = {16'h0, s[0] ? route(8'h4E, 4'hA, bt, bc)
                                  : route(8'h1B, 4'h5, at, ac)};
                chk({16'h0, neg, pos}, ex);
                chk({16'h0, lsel}, s[0] ? 24'h4E : 24'h1B);
            end
        end
        $display("routing test done");
        wr(8'h14, 8'hFF);
        idle(1);
        chk(dec, expdec(1'b0, 8'h2D, 8'hFF, 8'h0F));
        $display("equalizer test done");
        rstn = 1'b0;
        wr(8'h81, 8'h00);
        idle(1);
        rstn = 1'b1;
        chk(dec, expdec(1'b1, 8'h00, 8'hFF, 8'h03));
        chk({16'h0, lsel}, 24'hE4);
        for (int i = 0; i < 8; i++) rd(ofs[i], rstv[i]);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule

`default_nettype wire
